// ### src/mcg_params.svh
/*
  Constants for the maskable change-detect switch input port.
  Assumes inclusion by the package and the switch port module by bare name.
*/
`ifndef MCG_PARAMS_SVH
`define MCG_PARAMS_SVH

`define MCG_PORT_WIDTH 8
`define MCG_MSB 7
`define MCG_STATUS_RESET 8'h00
`define MCG_MASK_RESET 8'h00
`define MCG_SOFT_RESET_MASK 8'h00
`define MCG_SNAP_DEPTH 16
`define MCG_SYNC_IDLE_CS 1'b1

`endif

// ### src/mcg_pkg.sv
/*
  Types shared by the switch input port, its host model and its bench.
  Assumes mcg_params.svh sits on the include path.
*/
`include "mcg_params.svh"

package mcg_pkg;

  typedef logic [`MCG_PORT_WIDTH-1:0] mcg_byte_t;

  // Captured input status and live mask, kept together
  typedef struct packed {
    mcg_byte_t status;
    mcg_byte_t mask;
  } mcg_regs_t;

  // Shift path state within one chip-select frame
  typedef enum logic [1:0] {
    MCG_SH_LOAD  = 2'b01,
    MCG_SH_SHIFT = 2'b10
  } mcg_shift_state_t;

endpackage

// ### src/mcg_fifo.sv
/*
  Synchronous FIFO with valid and ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps

module mcg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_comb begin
    next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage needs no reset; out_valid guards its contents
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  a_fifo_no_overfill: assert property (@(posedge clk) disable iff (!arst_n)
    count <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");

endmodule

// ### src/mcg_switch_port.sv
/*
  Change-detecting 8-bit switch input port with maskable open-drain
  interrupt, a 4-wire serial access port and a snapshot FIFO.
  Assumes SCLK stands low around chip-select edges and that the host
  leaves at least four CLOCK periods between chip-select falling and
  the first SCLK rising edge, and between the last SCLK edge and the
  chip-select rising edge.
  // Overview of operation
  // - Interrupt pin only pulls low, open drain
  // - Mask bit one lets its input interrupt
  // - Enabled, unmasked mismatch drives interrupt low
  // - Chip-select fall or inputs matching clear interrupt
  // - Enable pin is active high
  // - Enable low keeps interrupt released
  // - Enable low holds last input state
  // - Interrupt lines wire-AND on shared pull-up
  // - Chip-select fall latches inputs into status
  // - Chip-select rise moves shift register to mask
  // - First SCLK rise loads, later shift, falls sample
  // - All-zero mask clears status and interrupt
*/
`timescale 1ns/10ps
`include "mcg_params.svh"

module mcg_switch_port
  import mcg_pkg::*;
#(
  parameter int WIDTH = `MCG_PORT_WIDTH,
  parameter int SNAP_DEPTH = `MCG_SNAP_DEPTH
) (
  // System clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // Serial access port
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  output logic SERIAL_OUT_OE,
  // Switch inputs and enable
  input wire logic [WIDTH-1:0] SWITCH_INPUTS,
  input wire logic INT_EN,
  // Open-drain interrupt
  output logic INT_N_O,
  output logic INT_N_OE,
  // Register view
  output mcg_regs_t REGS,
  // Snapshot stream
  output logic SNAP_VALID,
  input wire logic SNAP_READY,
  output mcg_byte_t SNAP_DATA,
  output logic SNAP_IN_READY
);

  // CLOCK domain synchronisers
  mcg_byte_t in_meta;
  mcg_byte_t in_sync;
  logic en_meta;
  logic en_sync;
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic cs_fall;
  logic cs_rise;

  // CLOCK domain state
  mcg_byte_t held;
  mcg_byte_t next_held;
  mcg_regs_t regs;
  mcg_regs_t next_regs;
  logic irq;
  logic next_irq;
  mcg_byte_t pending;

  // SCLK domain state
  mcg_shift_state_t sh_state;
  mcg_shift_state_t next_sh_state;
  mcg_byte_t shreg;
  mcg_byte_t next_shreg;
  logic out_bit;
  logic next_out_bit;
  logic in_bit;
  logic next_in_bit;
  mcg_byte_t frame_word;

  function automatic mcg_byte_t unmasked_diff(input mcg_byte_t live, input mcg_regs_t r);
    unmasked_diff = (live ^ r.status) & r.mask;
  endfunction

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      in_meta <= '0;
      in_sync <= '0;
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      cs_meta <= `MCG_SYNC_IDLE_CS;
      cs_sync <= `MCG_SYNC_IDLE_CS;
      cs_prev <= `MCG_SYNC_IDLE_CS;
    end else begin
      in_meta <= SWITCH_INPUTS;
      in_sync <= in_meta;
      en_meta <= INT_EN;
      en_sync <= en_meta;
      cs_meta <= CS_N;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  assign cs_fall = cs_prev & ~cs_sync;
  assign cs_rise = ~cs_prev & cs_sync;

  // Final mask: last falling-edge sample joins the shifted bits
  assign frame_word = {shreg[WIDTH-2:0], in_bit};
  assign pending = unmasked_diff(held, regs);

  always_comb begin
    next_held = held;
    next_regs = regs;
    // Inputs off while disabled: last seen state is presented
    if (en_sync) begin
      next_held = in_sync;
    end
    if (cs_fall) begin
      next_regs.status = held;
    end
    // Word is quasi-static here: SCLK has stopped for the frame
    if (cs_rise) begin
      next_regs.mask = frame_word;
      if (frame_word == `MCG_SOFT_RESET_MASK) begin
        next_regs.status = `MCG_STATUS_RESET;
      end
    end
    // Mismatch on an unmasked bit pulls the line; match releases it
    next_irq = en_sync & (|unmasked_diff(next_held, next_regs));
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      held <= '0;
      regs <= '{status: `MCG_STATUS_RESET, mask: `MCG_MASK_RESET};
      irq <= 1'b0;
    end else begin
      held <= next_held;
      regs <= next_regs;
      irq <= next_irq;
    end
  end

  // Pin never driven high, so several ports share one pull-up
  assign INT_N_O = 1'b0;
  assign INT_N_OE = irq;
  assign REGS = regs;

  // Frame state cleared by chip select itself; SCLK idles outside frames
  always_comb begin
    next_sh_state = MCG_SH_SHIFT;
    next_shreg = shreg;
    next_out_bit = out_bit;
    unique case (sh_state)
      MCG_SH_LOAD: begin
        next_shreg = regs.status;
        next_out_bit = regs.status[`MCG_MSB];
      end
      MCG_SH_SHIFT: begin
        next_shreg = {shreg[WIDTH-2:0], in_bit};
        next_out_bit = shreg[WIDTH-2];
      end
    endcase
  end

  // No system reset here: chip select alone returns the frame to its load step
  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      sh_state <= MCG_SH_LOAD;
    end else begin
      sh_state <= next_sh_state;
    end
  end

  // Shift contents must outlive the frame for the mask transfer
  always_ff @(posedge SCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      shreg <= '0;
      out_bit <= 1'b0;
    end else begin
      shreg <= next_shreg;
      out_bit <= next_out_bit;
    end
  end

  // Refused outside a frame, so a stray edge cannot disturb the mask word
  assign next_in_bit = CS_N ? in_bit : SERIAL_IN;

  always_ff @(negedge SCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      in_bit <= 1'b0;
    end else begin
      in_bit <= next_in_bit;
    end
  end

  assign SERIAL_OUT = out_bit;
  assign SERIAL_OUT_OE = ~CS_N;

  // Each captured status goes to the snapshot stream while it has room; one captured when full is dropped
  mcg_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(SNAP_DEPTH)
  ) u_snap (
    .clk(CLOCK),
    .arst_n(ARST_N),
    .in_valid(cs_fall),
    .in_ready(SNAP_IN_READY),
    .in_data(held),
    .out_valid(SNAP_VALID),
    .out_ready(SNAP_READY),
    .out_data(SNAP_DATA)
  );

  // Interrupt path
  a_int_disabled_off: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !en_sync |=> !INT_N_OE)
    else $error("Interrupt asserted while disabled");

  a_int_on_change: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    en_sync && !cs_fall && !cs_rise && (|pending) ##1 (held == $past(held))
    |-> INT_N_OE)
    else $error("Unmasked change did not pull interrupt");

  a_int_masked_quiet: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    en_sync && ((held ^ regs.status) != '0) && (pending == '0) && !cs_fall && !cs_rise
    ##1 (held == $past(held)) |-> !INT_N_OE)
    else $error("Masked change pulled the interrupt");

  a_int_pin_low: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    INT_N_O == 1'b0)
    else $error("Interrupt pin would drive high");

  a_int_needs_diff: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    INT_N_OE |-> (pending != '0))
    else $error("Interrupt held although inputs match status");

  a_int_follows_diff: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $past(en_sync) && (pending != '0) |-> INT_N_OE)
    else $error("Interrupt released with an unmasked mismatch");

  a_int_needs_enable: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    INT_N_OE |-> $past(en_sync))
    else $error("Interrupt asserted without the enable");

  // Chip-select transfers and held inputs
  a_status_latch: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    cs_fall && !cs_rise |=> regs.status == $past(held))
    else $error("Status not latched on chip-select fall");

  a_status_hold: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !cs_fall && !cs_rise |=> $stable(regs.status))
    else $error("Status changed between chip-select edges");

  a_cs_fall_clear: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    cs_fall ##1 (held == $past(held)) |-> !INT_N_OE)
    else $error("Interrupt not cleared after chip-select fall");

  a_mask_load: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    cs_rise |=> regs.mask == $past(frame_word))
    else $error("Mask not loaded on chip-select rise");

  a_mask_hold: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !cs_rise |=> $stable(regs.mask))
    else $error("Mask changed without chip-select rise");

  a_soft_reset: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    cs_rise && frame_word == '0 |=> regs.status == '0 ##1 !INT_N_OE)
    else $error("Zero mask did not reset status");

  a_held_input: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !en_sync |=> held == $past(held))
    else $error("Held inputs changed while disabled");

  a_held_tracks: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    en_sync |=> held == $past(in_sync))
    else $error("Enabled inputs not followed");

  a_snap_push: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    cs_fall && SNAP_IN_READY |=> SNAP_VALID)
    else $error("Captured status missing from snapshot stream");

  // Shift path, SCLK domain
  a_first_load: assert property (@(posedge SCLK) disable iff (CS_N || !ARST_N)
    sh_state == MCG_SH_LOAD |=> SERIAL_OUT == $past(regs.status[`MCG_MSB]))
    else $error("First SCLK rise did not present status MSB");

  a_load_shreg: assert property (@(posedge SCLK) disable iff (CS_N || !ARST_N)
    sh_state == MCG_SH_LOAD |=> shreg == $past(regs.status))
    else $error("Shift register not loaded from status");

  a_shift_next: assert property (@(posedge SCLK) disable iff (CS_N || !ARST_N)
    sh_state == MCG_SH_SHIFT |=> SERIAL_OUT == $past(shreg[WIDTH-2]))
    else $error("Serial output did not present the next bit");

  c_mask_written: cover property (@(posedge CLOCK) disable iff (!ARST_N) cs_rise && frame_word != '0);
  c_int_asserted: cover property (@(posedge CLOCK) disable iff (!ARST_N) !INT_N_OE ##1 INT_N_OE);
  c_soft_reset: cover property (@(posedge CLOCK) disable iff (!ARST_N) cs_rise && frame_word == '0);
  c_snap_full: cover property (@(posedge CLOCK) disable iff (!ARST_N) !SNAP_IN_READY);
  c_frame_shift: cover property (@(posedge SCLK) disable iff (CS_N || !ARST_N) sh_state == MCG_SH_SHIFT);

endmodule

// ### sim/mcg_host.sv
/*
  Serial host model that reads the switch snapshot and writes the mask.
  Assumes the bench clock for frame alignment and a resolved SERIAL_OUT line.
*/
`timescale 1ns/10ps

module mcg_host
  import mcg_pkg::*;
(
  // Bench clock
  input wire logic clk,
  // Serial lines
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  input wire logic serial_out
);
  // Idle levels while not selected: chip select high, SCLK and data low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end

  // One whole frame, MSB first; SCLK runs only inside it
  task automatic frame(input mcg_byte_t mask, output mcg_byte_t rd);
    int k;
    rd = 8'h00;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (6) @(negedge clk);
    #7;
    for (k = 7; k >= 0; k--) begin
      sclk = 1'b1;
      #1 serial_in = mask[k];
      #38 rd = {rd[6:0], serial_out};
      #1 sclk = 1'b0;
      #40;
    end
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    serial_in = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule

// ### sim/mcg_switch_port_test.sv
/*
  Self-checking bench for the switch input port, its interrupt and snapshot FIFO.
  Assumes the host model drives the serial port and a pull-up on the interrupt line.
*/
`timescale 1ns/10ps

module mcg_switch_port_test
  import mcg_pkg::*;
;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  mcg_byte_t switch_inputs = 8'h00;
  logic int_en = 1'b0;
  logic snap_ready = 1'b0;
  logic other_oe = 1'b0;
  logic sclk, cs_n, serial_in, serial_out, serial_out_oe, int_n_o, int_n_oe, snap_valid, snap_in_ready;
  mcg_regs_t regs;
  mcg_byte_t snap_data, rd;
  wire sdo_line;
  wire int_line;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;

  // Pull-up shared with a second open-drain device
  assign int_line = (int_n_oe ? int_n_o : 1'b1) & ~other_oe;
  assign sdo_line = serial_out_oe ? serial_out : 1'bz;

  always #12.5 clock = ~clock;

  mcg_switch_port dut (
    .CLOCK(clock), .ARST_N(arst_n), .SCLK(sclk), .CS_N(cs_n), .SERIAL_IN(serial_in),
    .SERIAL_OUT(serial_out), .SERIAL_OUT_OE(serial_out_oe), .SWITCH_INPUTS(switch_inputs),
    .INT_EN(int_en), .INT_N_O(int_n_o), .INT_N_OE(int_n_oe), .REGS(regs), .SNAP_VALID(snap_valid),
    .SNAP_READY(snap_ready), .SNAP_DATA(snap_data), .SNAP_IN_READY(snap_in_ready)
  );

  mcg_host host (.clk(clock), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .serial_out(sdo_line));

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Longer than sync plus interrupt latency
  task automatic set_in(input mcg_byte_t v);
    @(negedge clock);
    switch_inputs = v;
    repeat (6) @(negedge clock);
  endtask

  task automatic t_reset();
    check(regs, 16'h0000);
    check(int_line, 1'b1);
    check({snap_valid, snap_in_ready}, 2'h1);
    check({serial_out_oe, sdo_line}, 2'b0z);
  endtask

  task automatic t_mask_gate();
    set_in(8'hA5);
    int_en = 1'b1;
    repeat (6) @(negedge clock);
    host.frame(8'h0F, rd);
    check(rd, 8'hA5);
    check(regs, {8'hA5, 8'h0F});
    set_in(8'h25);
    check(int_n_oe, 1'b0);
    set_in(8'h24);
    check(int_n_oe, 1'b1);
    check({int_line, int_n_o}, 2'h0);
    set_in(8'h25);
    check(int_line, 1'b1);
    set_in(8'h27);
    check(int_n_oe, 1'b1);
    host.frame(8'h0F, rd);
    check(rd, 8'h27);
    check(int_n_oe, 1'b0);
  endtask

  // Held state differs from status while disabled, yet no interrupt
  task automatic t_enable();
    set_in(8'h25);
    check(int_n_oe, 1'b1);
    int_en = 1'b0;
    repeat (6) @(negedge clock);
    check(int_line, 1'b1);
    set_in(8'h5A);
    host.frame(8'h0F, rd);
    check(rd, 8'h25);
    check(regs, {8'h25, 8'h0F});
    int_en = 1'b1;
    repeat (6) @(negedge clock);
    check(int_n_oe, 1'b1);
  endtask

  task automatic t_soft_reset();
    host.frame(8'h00, rd);
    check(rd, 8'h5A);
    check(regs, 16'h0000);
    check(int_line, 1'b1);
    other_oe = 1'b1;
    @(negedge clock);
    check(int_line, 1'b0);
    other_oe = 1'b0;
  endtask

  // Far side stalls while sixteen snapshots fill the buffer
  task automatic t_fifo();
    int i;
    snap_ready = 1'b1;
    repeat (20) @(negedge clock);
    snap_ready = 1'b0;
    check(snap_valid, 1'b0);
    for (i = 1; i <= 17; i++) begin
      set_in(i[7:0]);
      host.frame(8'h00, rd);
    end
    check(snap_in_ready, 1'b0);
    snap_ready = 1'b1;
    for (i = 1; i <= 16; i++) begin
      check({snap_valid, snap_data}, {1'b1, i[7:0]});
      @(negedge clock);
    end
    check(snap_valid, 1'b0);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (10) @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    t_reset();
    t_mask_gate();
    t_enable();
    t_soft_reset();
    t_fifo();
    end_of_test();
  end
endmodule
